// *** rtl/id_refresh_defs.svh ***
// Constants of the identification and refresh-range register bank
`ifndef ID_REFRESH_DEFS_SVH
`define ID_REFRESH_DEFS_SVH

// Register selector on upper address bits 19:18
`define SEL_CFG 2'h0
`define SEL_ID 2'h1
`define SEL_HI_BIT 19
`define SEL_LO_BIT 18

// Data word on third cycle of the software sequence
`define SEQ_DATA_CFG 16'h0000
`define SEQ_DATA_ID 16'h0002

// Highest word address of the 16Mb array
`define TOP_WORD 20'hfffff

// Refresh configuration word
`define CFG_RESET 16'h0000
`define RANGE_HI_BIT 2
`define RANGE_LO_BIT 0
`define RANGE_RESET 3'h0

// Refresh range codes
`define RANGE_FULL 3'h0
`define RANGE_LO_HALF 3'h1
`define RANGE_LO_QTR 3'h2
`define RANGE_LO_8TH 3'h3
`define RANGE_NONE 3'h4
`define RANGE_HI_HALF 3'h5
`define RANGE_HI_QTR 3'h6
`define RANGE_HI_8TH 3'h7

// Range bounds, word addresses
`define BOTTOM_WORD 20'h00000
`define LO_HALF_TOP 20'h7ffff
`define LO_QTR_TOP 20'h3ffff
`define LO_8TH_TOP 20'h1ffff
`define HI_HALF_BASE 20'h80000
`define HI_QTR_BASE 20'hc0000
`define HI_8TH_BASE 20'he0000

// Identification word fields
`define ID_ROW_BIT 15
`define ID_VER_HI 14
`define ID_VER_LO 11
`define ID_DENS_HI 10
`define ID_DENS_LO 8
`define ID_GEN_HI 7
`define ID_GEN_LO 5
`define ID_MAKER_HI 4
`define ID_MAKER_LO 0

// Row length encodings
`define ROW_512 1'h0
`define ROW_256 1'h1

// Density encodings
`define DENS_16MB 3'h0
`define DENS_32MB 3'h1
`define DENS_64MB 3'h2
`define DENS_128MB 3'h3
`define DENS_256MB 3'h4
`define DENS_512MB 3'h5

// Generation encodings
`define GEN_1_0 3'h1
`define GEN_1_5 3'h2
`define GEN_2_0 3'h3

// Synchroniser width: ce, adv, we, oe, select, a19..16, adq
`define SYNC_W 25

`endif

// *** rtl/id_refresh_pkg.sv ***
// Types of the identification and refresh-range register bank
package id_refresh_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_RD1 = 3'b001,
    SEQ_RD2 = 3'b010,
    SEQ_ARMED = 3'b011
  } seq_state_e;

  typedef logic [19:0] word_addr_t;

endpackage

// *** rtl/id_register_and_refresh_range.sv ***
// Identification word and refresh-range register bank on a muxed bus
//
// Operation
// - Codes 000 to 011 keep refreshed the full array, lower half, lower quarter and lower eighth from word zero.
// - Code 100 refreshes nothing and codes 101 to 111 refresh the upper half, quarter and eighth ending at the top word.
// - The identification word is read-only on every access path.
// - Select pin high with address bits 19:18 at 01 turns the access into an identification word access.
// - The software sequence with 0002h on its third cycle also reaches the identification word.
// - The identification word holds row length, version, density, generation and maker code in fixed fields.
// - The row-length bit reads 0 for 512-word rows and 1 for 256-word rows.
// - The density field encodes 16Mb to 512Mb as 000 to 101.
// - Version, generation and maker code are fixed values of the part.
// - The refresh configuration word, range in bits 2:0, is reached by select pin with 00 or by the sequence with 0000h.
// - The refresh configuration word starts at zero, meaning full-array refresh.
`timescale 1ns/1ns
`include "id_refresh_defs.svh"
`default_nettype none

module id_register_and_refresh_range #(
  // Values arbitrary
  parameter logic [3:0] VERSION_CODE = 4'h5,
  parameter logic [4:0] MAKER_CODE = 5'h12,
  parameter logic [2:0] GEN_CODE = `GEN_1_5,
  parameter logic ROW_CODE = `ROW_256
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins
  input wire logic ce_n,
  input wire logic adv_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic register_select_pin,
  input wire logic [3:0] addr_upper,
  input wire logic [15:0] adq_in,
  output logic [15:0] adq_out,
  output logic adq_oe_n,
  // Status toward array logic
  output logic reg_access,
  // Refresh range
  output logic refresh_none,
  output logic [19:0] refresh_base,
  output logic [19:0] refresh_top
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [`SYNC_W-1:0] sync_a_ff;
  logic [`SYNC_W-1:0] sync_b_ff;
  logic [`SYNC_W-1:0] nxt_sync_a;
  logic [`SYNC_W-1:0] nxt_sync_b;

  always_comb
  begin
    nxt_sync_a = {ce_n, adv_n, we_n, oe_n, register_select_pin,
                  addr_upper, adq_in};
    nxt_sync_b = sync_a_ff;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_a_ff <= {5'h1f, 20'h00000};
      sync_b_ff <= {5'h1f, 20'h00000};
    end
    else
    begin
      sync_a_ff <= nxt_sync_a;
      sync_b_ff <= nxt_sync_b;
    end
  end

  logic ce_s;
  logic adv_s;
  logic we_s;
  logic oe_s;
  logic sel_s;
  logic [3:0] upper_s;
  logic [15:0] adq_s;
  assign {ce_s, adv_s, we_s, oe_s, sel_s, upper_s, adq_s} = sync_b_ff;

  ////////////////////////////////////////////////////////////////////////
  // Access tracking and register bank
  logic ce_prev_ff;
  logic sel_lat_ff;
  id_refresh_pkg::word_addr_t addr_lat_ff;
  logic wr_seen_ff;
  logic [15:0] wdata_ff;
  logic [2:0] range_ff;
  id_refresh_pkg::seq_state_e seq_ff;
  logic [1:0] seq_sel_ff;
  logic [15:0] adq_out_ff;
  logic refresh_none_ff;
  id_refresh_pkg::word_addr_t refresh_base_ff;
  id_refresh_pkg::word_addr_t refresh_top_ff;

  logic nxt_ce_prev;
  logic nxt_sel_lat;
  id_refresh_pkg::word_addr_t nxt_addr_lat;
  logic nxt_wr_seen;
  logic [15:0] nxt_wdata;
  logic [2:0] nxt_range;
  id_refresh_pkg::seq_state_e nxt_seq;
  logic [1:0] nxt_seq_sel;
  logic [15:0] nxt_adq_out;
  logic nxt_refresh_none;
  id_refresh_pkg::word_addr_t nxt_refresh_base;
  id_refresh_pkg::word_addr_t nxt_refresh_top;

  logic [15:0] id_word;
  logic [15:0] cfg_word;
  logic access_end;
  logic reg_cycle;
  logic [1:0] target;
  logic at_top;

  always_comb
  begin
    id_word = 16'h0000;
    id_word[`ID_ROW_BIT] = ROW_CODE;
    id_word[`ID_VER_HI:`ID_VER_LO] = VERSION_CODE;
    id_word[`ID_DENS_HI:`ID_DENS_LO] = `DENS_16MB;
    id_word[`ID_GEN_HI:`ID_GEN_LO] = GEN_CODE;
    id_word[`ID_MAKER_HI:`ID_MAKER_LO] = MAKER_CODE;
    cfg_word = `CFG_RESET;
    cfg_word[`RANGE_HI_BIT:`RANGE_LO_BIT] = range_ff;

    // Access ends on the release of chip enable
    access_end = ce_s && !ce_prev_ff;
    at_top = (addr_lat_ff == `TOP_WORD);
    // Select pin wins over an armed sequence
    reg_cycle = sel_lat_ff || (seq_ff == id_refresh_pkg::SEQ_ARMED);
    target = sel_lat_ff ? addr_lat_ff[`SEL_HI_BIT:`SEL_LO_BIT] : seq_sel_ff;

    nxt_ce_prev = ce_s;
    nxt_sel_lat = sel_lat_ff;
    nxt_addr_lat = addr_lat_ff;
    nxt_wr_seen = wr_seen_ff;
    nxt_wdata = wdata_ff;
    nxt_range = range_ff;
    nxt_seq = seq_ff;
    nxt_seq_sel = seq_sel_ff;

    if (!ce_s && !adv_s)
    begin
      nxt_addr_lat = {upper_s, adq_s};
      nxt_sel_lat = sel_s;
    end
    if (!ce_s && !we_s)
    begin
      nxt_wr_seen = 1'b1;
      nxt_wdata = adq_s;
    end

    if (access_end)
    begin
      nxt_wr_seen = 1'b0;
      nxt_sel_lat = 1'b0;
      // Identification word writes fall through untouched
      if (reg_cycle && wr_seen_ff && target == `SEL_CFG)
        nxt_range = wdata_ff[`RANGE_HI_BIT:`RANGE_LO_BIT];
      case (seq_ff)
        id_refresh_pkg::SEQ_IDLE:
          if (!sel_lat_ff && at_top && !wr_seen_ff)
            nxt_seq = id_refresh_pkg::SEQ_RD1;
        id_refresh_pkg::SEQ_RD1:
          if (!sel_lat_ff && at_top && !wr_seen_ff)
            nxt_seq = id_refresh_pkg::SEQ_RD2;
          else
            nxt_seq = id_refresh_pkg::SEQ_IDLE;
        id_refresh_pkg::SEQ_RD2:
          if (!sel_lat_ff && at_top && wr_seen_ff &&
              wdata_ff == `SEQ_DATA_ID)
          begin
            nxt_seq = id_refresh_pkg::SEQ_ARMED;
            nxt_seq_sel = `SEL_ID;
          end
          else if (!sel_lat_ff && at_top && wr_seen_ff &&
                   wdata_ff == `SEQ_DATA_CFG)
          begin
            nxt_seq = id_refresh_pkg::SEQ_ARMED;
            nxt_seq_sel = `SEL_CFG;
          end
          else
            nxt_seq = id_refresh_pkg::SEQ_IDLE;
        default:
          nxt_seq = id_refresh_pkg::SEQ_IDLE;
      endcase
    end

    // Read data registered each cycle from the current target, whether or not a register cycle runs
    if (target == `SEL_ID)
      nxt_adq_out = id_word;
    else if (target == `SEL_CFG)
      nxt_adq_out = cfg_word;
    else
      nxt_adq_out = 16'h0000;

    nxt_refresh_none = 1'b0;
    nxt_refresh_base = `BOTTOM_WORD;
    nxt_refresh_top = `TOP_WORD;
    case (range_ff)
      `RANGE_FULL: nxt_refresh_top = `TOP_WORD;
      `RANGE_LO_HALF: nxt_refresh_top = `LO_HALF_TOP;
      `RANGE_LO_QTR: nxt_refresh_top = `LO_QTR_TOP;
      `RANGE_LO_8TH: nxt_refresh_top = `LO_8TH_TOP;
      `RANGE_NONE: nxt_refresh_none = 1'b1;
      `RANGE_HI_HALF: nxt_refresh_base = `HI_HALF_BASE;
      `RANGE_HI_QTR: nxt_refresh_base = `HI_QTR_BASE;
      default: nxt_refresh_base = `HI_8TH_BASE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ce_prev_ff <= 1'b1;
      sel_lat_ff <= 1'b0;
      addr_lat_ff <= 20'h00000;
      wr_seen_ff <= 1'b0;
      wdata_ff <= 16'h0000;
      range_ff <= `RANGE_RESET;
      seq_ff <= id_refresh_pkg::SEQ_IDLE;
      seq_sel_ff <= `SEL_CFG;
      adq_out_ff <= 16'h0000;
      refresh_none_ff <= 1'b0;
      refresh_base_ff <= `BOTTOM_WORD;
      refresh_top_ff <= `TOP_WORD;
    end
    else
    begin
      ce_prev_ff <= nxt_ce_prev;
      sel_lat_ff <= nxt_sel_lat;
      addr_lat_ff <= nxt_addr_lat;
      wr_seen_ff <= nxt_wr_seen;
      wdata_ff <= nxt_wdata;
      range_ff <= nxt_range;
      seq_ff <= nxt_seq;
      seq_sel_ff <= nxt_seq_sel;
      adq_out_ff <= nxt_adq_out;
      refresh_none_ff <= nxt_refresh_none;
      refresh_base_ff <= nxt_refresh_base;
      refresh_top_ff <= nxt_refresh_top;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; array logic owns the bus outside register cycles
  logic known_target;
  assign known_target = (target == `SEL_ID) || (target == `SEL_CFG);
  assign reg_access = reg_cycle && !ce_s;
  assign adq_oe_n = !(reg_cycle && known_target && !ce_s && !oe_s &&
                      !wr_seen_ff);
  assign adq_out = adq_out_ff;
  assign refresh_none = refresh_none_ff;
  assign refresh_base = refresh_base_ff;
  assign refresh_top = refresh_top_ff;

endmodule // id_register_and_refresh_range

`default_nettype wire

// *** tb/id_refresh_chk.sv ***
// Port assertions of the identification and refresh-range bank
`timescale 1ns/1ns
`include "id_refresh_defs.svh"
`default_nettype none
module id_refresh_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic adq_oe_n,
  // Status and range
  input wire logic reg_access,
  input wire logic refresh_none,
  input wire logic [19:0] refresh_base,
  input wire logic [19:0] refresh_top
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Long enough that any earlier access end has landed
  sequence s_busy;
    !ce_n [*6];
  endsequence
  a_reset_full_range: assert property ($fell(rst) |->
    refresh_top == `TOP_WORD && refresh_base == `BOTTOM_WORD && !refresh_none)
    else $error("range not full after reset");
  a_lower_range_top: assert property (
    refresh_base == `BOTTOM_WORD && !refresh_none |-> refresh_top inside
    {`TOP_WORD, `LO_HALF_TOP, `LO_QTR_TOP, `LO_8TH_TOP})
    else $error("lower range top wrong");
  a_upper_range_base: assert property (
    refresh_base != `BOTTOM_WORD |-> refresh_top == `TOP_WORD && !refresh_none
    && refresh_base inside {`HI_HALF_BASE, `HI_QTR_BASE, `HI_8TH_BASE})
    else $error("upper range base wrong");
  a_range_stable_busy: assert property (s_busy |=>
    $stable(refresh_base) && $stable(refresh_top) && $stable(refresh_none))
    else $error("range moved inside an access");
  a_drive_needs_oe: assert property (
    !adq_oe_n |-> !$past(oe_n, 2) || !$past(oe_n, 3))
    else $error("data driven without output enable");
  a_drive_needs_ce: assert property (
    !adq_oe_n |-> !$past(ce_n, 2) || !$past(ce_n, 3))
    else $error("data driven without chip enable");
  a_drive_reg_only: assert property (!adq_oe_n |-> reg_access)
    else $error("data driven outside register cycle");
  a_reg_needs_ce: assert property (
    reg_access |-> !$past(ce_n, 2) || !$past(ce_n, 3))
    else $error("register cycle without chip enable");
endmodule // id_refresh_chk
`default_nettype wire

// *** tb/bus_ctrl_model.sv ***
// Memory controller model driving the muxed register bus pins
`timescale 1ns/1ns
`default_nettype none
module bus_ctrl_model (
  // Clock
  input wire logic clk,
  // Pins toward the device
  output logic ce_n,
  output logic adv_n,
  output logic we_n,
  output logic oe_n,
  output logic register_select_pin,
  output logic [3:0] addr_upper,
  output logic [15:0] adq_in,
  // Read data from the device
  input wire logic [15:0] adq_out,
  input wire logic adq_oe_n
);
  initial
  begin
    ce_n = 1'b1;
    adv_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    register_select_pin = 1'b0;
    addr_upper = 4'h0;
    adq_in = 16'h0000;
  end
  // Every phase two clocks or more, except the one clock from output/write enable release to chip enable release
  task automatic access(input logic sel, input logic [19:0] a,
    input logic wr, input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    ce_n = 1'b0;
    adv_n = 1'b0;
    register_select_pin = sel;
    addr_upper = a[19:16];
    adq_in = a[15:0];
    repeat (2) @(negedge clk);
    adv_n = 1'b1;
    // A read leaves the bus to the device: show the inverse, not stale data
    adq_in = wr ? d : ~a[15:0];
    we_n = !wr;
    oe_n = wr;
    repeat (4) @(negedge clk);
    q = (adq_oe_n === 1'b0) ? adq_out : 16'hxxxx;
    we_n = 1'b1;
    oe_n = 1'b1;
    @(negedge clk);
    ce_n = 1'b1;
    adq_in = ~adq_in;
    repeat (5) @(negedge clk);
  endtask
endmodule // bus_ctrl_model
`default_nettype wire

// *** tb/id_register_and_refresh_range_tb.sv ***
// Self-checking bench of the identification and refresh-range bank
`timescale 1ns/1ns
`include "id_refresh_defs.svh"
`default_nettype none
module id_register_and_refresh_range_tb;
  localparam logic [3:0] VER = 4'h3; // Arbitrary
  localparam logic [4:0] MKR = 5'h0a; // Arbitrary
  localparam logic [15:0] ID_WORD = {`ROW_256, VER, `DENS_16MB, `GEN_2_0, MKR};
  localparam logic [19:0] CFG_A = {`SEL_CFG, 18'h0};
  localparam logic [19:0] BASES [8] = '{`BOTTOM_WORD, `BOTTOM_WORD,
    `BOTTOM_WORD, `BOTTOM_WORD, `BOTTOM_WORD, `HI_HALF_BASE, `HI_QTR_BASE,
    `HI_8TH_BASE};
  localparam logic [19:0] TOPS [8] = '{`TOP_WORD, `LO_HALF_TOP, `LO_QTR_TOP,
    `LO_8TH_TOP, `TOP_WORD, `TOP_WORD, `TOP_WORD, `TOP_WORD};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce_n, adv_n, we_n, oe_n, sel, adq_oe_n, reg_access, refresh_none;
  logic [3:0] a_hi;
  logic [15:0] adq_in, adq_out, q;
  logic [19:0] base, top;
  int mismatches = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  id_register_and_refresh_range #(.VERSION_CODE(VER), .MAKER_CODE(MKR),
    .GEN_CODE(`GEN_2_0), .ROW_CODE(`ROW_256)) id_register_and_refresh_range_i (
    .clk(clk), .rst(rst), .ce_n(ce_n), .adv_n(adv_n), .we_n(we_n),
    .oe_n(oe_n), .register_select_pin(sel), .addr_upper(a_hi),
    .adq_in(adq_in), .adq_out(adq_out), .adq_oe_n(adq_oe_n),
    .reg_access(reg_access), .refresh_none(refresh_none),
    .refresh_base(base), .refresh_top(top));
  bus_ctrl_model bus_ctrl_model_i (.clk(clk), .ce_n(ce_n), .adv_n(adv_n),
    .we_n(we_n), .oe_n(oe_n), .register_select_pin(sel), .addr_upper(a_hi),
    .adq_in(adq_in), .adq_out(adq_out), .adq_oe_n(adq_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [19:0] seen,
    input logic [19:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset();
    check("none", refresh_none, 1'b0);
    check("base", base, `BOTTOM_WORD);
    check("top", top, `TOP_WORD);
    bus_ctrl_model_i.access(1'b1, CFG_A, 1'b0, 16'h0000, q);
    check("cfg", q, `CFG_RESET);
  endtask
  task automatic t_ranges();
    for (int c = 7; c >= 0; c--)
    begin
      bus_ctrl_model_i.access(1'b1, CFG_A, 1'b1, {13'h0, c[2:0]}, q);
      check("none", refresh_none, c == 4);
      if (c != 4)
      begin
        check("base", base, BASES[c]);
        check("top", top, TOPS[c]);
      end
      bus_ctrl_model_i.access(1'b1, CFG_A, 1'b0, 16'h0000, q);
      check("cfg", q, {13'h0, c[2:0]});
    end
  endtask
  task automatic t_id();
    bus_ctrl_model_i.access(1'b1, {`SEL_ID, 18'h0}, 1'b0, 16'h0000, q);
    check("id", q, ID_WORD);
    bus_ctrl_model_i.access(1'b1, {`SEL_ID, 18'h0}, 1'b1, ~ID_WORD, q);
    bus_ctrl_model_i.access(1'b1, {`SEL_ID, 18'h0}, 1'b0, 16'h0000, q);
    check("id kept", q, ID_WORD);
    check("base kept", base, `BOTTOM_WORD);
    bus_ctrl_model_i.access(1'b1, {2'h2, 18'h0}, 1'b0, 16'h0000, q);
    check("no drive", q, 16'hxxxx);
  endtask
  // Two top-word reads, then a top-word write that picks the register
  task automatic arm(input logic [15:0] pick);
    bus_ctrl_model_i.access(1'b0, `TOP_WORD, 1'b0, 16'h0000, q);
    bus_ctrl_model_i.access(1'b0, `TOP_WORD, 1'b0, 16'h0000, q);
    bus_ctrl_model_i.access(1'b0, `TOP_WORD, 1'b1, pick, q);
  endtask
  task automatic t_soft();
    arm(`SEQ_DATA_ID);
    bus_ctrl_model_i.access(1'b0, 20'h00000, 1'b0, 16'h0000, q);
    check("soft id", q, ID_WORD);
    arm(`SEQ_DATA_CFG);
    bus_ctrl_model_i.access(1'b0, 20'h00000, 1'b1, 16'h0003, q);
    check("soft top", top, `LO_8TH_TOP);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_ranges();
    t_id();
    t_soft();
    stop_test();
  end
  // Run needs well under a tenth of this
  initial
  begin
    #400000;
    mismatches++;
    stop_test();
  end
endmodule // id_register_and_refresh_range_tb
bind id_register_and_refresh_range id_refresh_chk id_refresh_chk_i (
  .clk(clk), .rst(rst), .ce_n(ce_n), .oe_n(oe_n), .adq_oe_n(adq_oe_n),
  .reg_access(reg_access), .refresh_none(refresh_none),
  .refresh_base(refresh_base), .refresh_top(refresh_top));
`default_nettype wire
